/* core/status_dispatch.sv */
// status byte upkeep and reserved opcode dispatch for the 16-bit core
`timescale 1ns/1ps
`include "status_dispatch_map.svh"
module status_dispatch
  import status_dispatch_pkg::*;
(
  input  wire logic        mclk_in,         // core clock, 50 MHz
  input  wire logic        rstn_in,         // async reset, active low
  input  wire logic        exec_in,         // one-cycle instruction strobe
  input  wire logic [15:0] opcode_in,       // fetched instruction word
  input  wire logic [1:0]  words_in,        // words the instruction takes
  input  wire logic [3:0]  alu_flags_in,    // N Z V C from the alu
  input  wire logic [7:0]  load_byte_in,    // vector, stack or source byte
  input  wire logic [15:0] pc_load_in,      // new program counter
  input  wire logic        pc_load_en_in,   // override program counter
  input  wire logic [15:0] dump_base_in,    // base register for the dump
  input  wire logic        ustore_en_in,    // user microstore fitted and on
  input  wire logic [23:0] mib_data_in,     // microstore return word
  output logic [7:0]       status_out,      // status byte
  output logic [15:0]      pc_out,          // program counter R7
  output logic [15:0]      sp_out,          // stack pointer R6
  output logic [15:0]      from_psb_out,    // move-from-status result
  output logic [15:0]      dump_reg_out,    // base register after dump
  output logic             trap_out,        // reserved-instruction trap
  output logic [15:0]      trap_vec_out,    // trap vector address
  output logic [2:0]       src_mode_out,    // source address mode
  output logic [2:0]       dst_mode_out,    // destination address mode
  output logic             pc_mode_out,     // operand uses PC modes
  output logic [10:0]      mib_addr_out,    // microaddress on the bus
  output logic             mib_rd_out,      // microstore read strobe
  output logic [23:0]      uword_out,       // fetched microinstruction
  output logic             uvalid_out       // microinstruction valid
);
  // ----------------------------------------------------------------
  // opcode classification
  // ----------------------------------------------------------------
  // shared range check; used by the extended and user decoders below
  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  wire is_op220   = (opcode_in[15:3] == `OP_220_BASE >> 3);      // 220-227
  wire is_opdump  = (opcode_in[15:3] == `OP_DUMP_BASE >> 3);     // 21R
  wire is_op0750  = in_range(opcode_in, `OP_EXT_LO, `OP_EXT_HI);
  wire is_op0766  = (opcode_in[15:9] == `OP_0766_BASE >> 9);      // 076xxx
  wire is_user    = in_range(opcode_in, `OP_USER_LO, `OP_USER_HI);
  wire is_from    = (opcode_in[15:6] == 10'h237);                 // 1067dd
  wire is_to      = (opcode_in[15:6] == 10'h234);                 // 1064ss
  wire is_ccop    = (opcode_in[15:5] == 11'h005);                 // 000240-000277
  // bus reset (000005) sits inside the trap range but must leave status alone
  wire is_trapop  = (opcode_in[15:9] == 7'h44) || (opcode_in[15:3] == 13'h0000 &&
                    opcode_in[2:0] >= 3'h2 && opcode_in[2:0] <= 3'h6 && opcode_in[2:0] != 3'h5);
  wire is_ctrl    = (opcode_in[15:8] <= 8'h07 && opcode_in[15:8] != 8'h00) ||
                    (opcode_in[15:6] == 10'h001) || (opcode_in[15:9] == 7'h04) ||
                    (opcode_in[15:9] == 7'h3f) || (opcode_in[15:8] >= 8'h80 &&
                    opcode_in[15:8] <= 8'h87) || (opcode_in[15:3] == 13'h0010) ||
                    (opcode_in[15:3] == 13'h0000 && opcode_in[2:0] <= 3'h1) ||
                    (opcode_in[15:3] == 13'h0000 && opcode_in[2:0] == 3'h5);
  wire dispatch   = is_op220 || is_op0750 || is_op0766;

  // microaddress for the reserved groups
  wire [10:0] uaddr = is_op220 ? `UADDR_OP220 :
                      is_op0750 ? `UADDR_OP0750 :
                      `UADDR_OP0766;

  // ----------------------------------------------------------------
  // status byte next value
  // ----------------------------------------------------------------
  logic [7:0] status;                         // working status byte
  wire  [7:0] status_w = status & `PSB_WORK_MASK;
  wire        zero_all = (status_w == 8'h00);
  // condition op: bit 4 selects set, low four bits pick the flags
  wire  [3:0] cc_sel   = opcode_in[3:0];
  wire  [3:0] cc_new   = opcode_in[4] ? (status_w[3:0] | cc_sel)
                                      : (status_w[3:0] & ~cc_sel);
  // move to status: trace may drop but never rise
  wire        trace_to = status_w[`PSB_BIT_TRACE] & load_byte_in[`PSB_BIT_TRACE];
  wire  [7:0] to_byte  = {load_byte_in[7], 2'b00, trace_to, load_byte_in[3:0]};
  // move from status flags, carry kept
  wire  [3:0] from_cc  = {status_w[7], zero_all, 1'b0, status_w[`PSB_BIT_C]};

  logic [7:0] next_status;
  // priority: the reserved dispatch and control classes never touch status
  always_comb
  begin
    next_status = status_w;
    if (exec_in && !dispatch)
    begin
      if (is_trapop)
        next_status = load_byte_in & `PSB_WORK_MASK;
      else if (is_to)
        next_status = to_byte;
      else if (is_from)
        next_status = {status_w[7:4], from_cc};
      else if (is_ccop)
        next_status = {status_w[7:4], cc_new};
      else if (!is_ctrl)
        next_status = {status_w[7:4], alu_flags_in};
    end
  end

  // ----------------------------------------------------------------
  // program counter, stack and dump base
  // ----------------------------------------------------------------
  wire [15:0] next_pc   = pc_load_en_in ? pc_load_in :
                          (pc_out + {13'h0000, words_in, 1'b0});
  // dump writes five temporaries, base is left pointing past them
  wire [15:0] next_dump = dump_base_in + 16'h000a;
  wire [15:0] from_word = {{8{status_w[7]}}, status_w};
  // a dispatch group with no store fitted traps through the reserved vector
  wire        trap_now  = exec_in && dispatch && !ustore_en_in;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // one process for the architectural state so resets agree
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      status       <= `PSB_RESET;
      status_out   <= `PSB_RESET;
      pc_out       <= 16'h0000;
      sp_out       <= 16'h0000;
      from_psb_out <= 16'h0000;
      dump_reg_out <= 16'h0000;
      trap_out     <= 1'b0;
      trap_vec_out <= 16'h0000;
      src_mode_out <= 3'h0;
      dst_mode_out <= 3'h0;
      pc_mode_out  <= 1'b0;
    end
    else
    begin
      status     <= next_status;
      status_out <= next_status;
      trap_out   <= trap_now;
      if (trap_now)
        trap_vec_out <= `TRAP_VEC_RESERVED;
      if (exec_in || pc_load_en_in)
        pc_out <= next_pc;
      // trap entry pushes two words on the stack held in R6
      if (trap_now || (exec_in && is_trapop && opcode_in[15:9] == 7'h44))
        sp_out <= sp_out - 16'h0004;
      if (exec_in && is_from)
        from_psb_out <= (opcode_in[5:3] == 3'h0) ? from_word : {8'h00, status_w};
      if (exec_in && is_opdump)
        dump_reg_out <= next_dump;
      if (exec_in)
      begin
        src_mode_out <= opcode_in[11:9];
        dst_mode_out <= opcode_in[5:3];
        pc_mode_out  <= (opcode_in[2:0] == 3'h7);
      end
    end
  end

  // ----------------------------------------------------------------
  // microstore fetch through the read-only bus port
  // ----------------------------------------------------------------
  ustore_fetch_port ustore_fetch_port_inst (
    .mclk_in      (mclk_in),
    .rstn_in      (rstn_in),
    .start_in     (exec_in && dispatch && ustore_en_in),
    .uaddr_in     (uaddr),
    .mib_data_in  (mib_data_in),
    .mib_addr_out (mib_addr_out),
    .mib_rd_out   (mib_rd_out),
    .uword_out    (uword_out),
    .uvalid_out   (uvalid_out)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // reserved bits never leave the flop as ones
  a_reserved_zero: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    status_out[6:5] == 2'b00)
    else $error("reserved status bits set");

  // data ops may not touch priority or trace
  a_data_keeps_hi: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (exec_in && !dispatch && !is_trapop && !is_to && !is_from && !is_ccop)
    |=> status_out[7:4] == $past(status_w[7:4]))
    else $error("data op changed priority or trace");

  // data ops take their flags straight from the alu
  a_data_flags: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (exec_in && !dispatch && !is_trapop && !is_to && !is_from && !is_ccop && !is_ctrl)
    |=> status_out[3:0] == $past(alu_flags_in))
    else $error("data op flags not from alu");

  // branches, jumps, halt, wait, reset and loop ops leave status alone
  a_ctrl_no_change: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (exec_in && is_ctrl && !is_trapop && !is_to && !is_from && !is_ccop && !dispatch)
    |=> status_out == $past(status_w))
    else $error("control op changed status");

  // trap class loads every working bit from the supplied byte
  a_trap_loads: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (exec_in && is_trapop && !dispatch) |=> status_out == ($past(load_byte_in) & `PSB_WORK_MASK))
    else $error("trap class load wrong");

  // set form: every selected flag ends up high, upper bits kept
  a_cc_set: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (exec_in && is_ccop && !dispatch && opcode_in[4])
    |=> ((status_out[3:0] & $past(opcode_in[3:0])) == $past(opcode_in[3:0])) &&
        (status_out[7:4] == $past(status_w[7:4])))
    else $error("condition set op wrong");

  // clear form: every selected flag ends up low, upper bits kept
  a_cc_clear: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (exec_in && is_ccop && !dispatch && !opcode_in[4])
    |=> ((status_out[3:0] & $past(opcode_in[3:0])) == 4'h0) &&
        (status_out[7:4] == $past(status_w[7:4])))
    else $error("condition clear op wrong");

  // register destination gets bit 7 copied through the upper byte
  a_from_word: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (exec_in && is_from && !dispatch && opcode_in[5:3] == 3'h0)
    |=> from_psb_out == {{8{$past(status_w[7])}}, $past(status_w)})
    else $error("move from status word wrong");

  // negative from bit 7, overflow cleared, carry kept
  a_from_flags: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (exec_in && is_from && !dispatch) |=> (status_out[3] == $past(status_w[7])) &&
    !status_out[1] && (status_out[0] == $past(status_w[0])))
    else $error("move from status flags wrong");

  // zero only when the whole byte was zero
  a_from_zero: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (exec_in && is_from && !dispatch) |=> status_out[2] == ($past(status_w) == 8'h00))
    else $error("move from status zero flag wrong");

  // trace can only fall through move to status
  a_trace_no_set: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (exec_in && is_to && !dispatch && !status_w[4]) |=> !status_out[4])
    else $error("move to status set trace");

  // flags and priority follow the source byte
  a_to_loads: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (exec_in && is_to && !dispatch) |=> (status_out[3:0] == $past(load_byte_in[3:0])) &&
    (status_out[7] == $past(load_byte_in[7])))
    else $error("move to status load wrong");

  // dump leaves its base register past the five temporaries
  a_dump_base: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (exec_in && is_opdump) |=> dump_reg_out == $past(dump_base_in) + 16'h000a)
    else $error("dump base not advanced");

  // no store: the first reserved group traps through the fixed vector
  a_trap_absent: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (exec_in && is_op220 && !ustore_en_in) |=> trap_out && trap_vec_out == 16'h0008)
    else $error("missing reserved trap");

  // no dispatch group changes the status byte
  a_dispatch_keeps: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (exec_in && dispatch) |=> status_out == $past(status_w))
    else $error("dispatch op changed status");

  // store fitted: the first reserved group goes to 3000
  a_op220_dispatch: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (exec_in && is_op220 && ustore_en_in) |=> mib_addr_out == `UADDR_OP220 && mib_rd_out)
    else $error("op 220 not sent to 3000");

  // store fitted: the extended group goes to 3003
  a_ext_dispatch: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (exec_in && is_op0750 && ustore_en_in) |=> mib_addr_out == 11'h603)
    else $error("extended op not sent to 3003");

  // no store: the extended group traps as well
  a_ext_trap: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (exec_in && is_op0750 && !ustore_en_in) |=> trap_out && trap_vec_out == `TRAP_VEC_RESERVED)
    else $error("missing extended trap");

  // user group goes to 3001 with a read strobe
  a_user_dispatch: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (exec_in && is_user && ustore_en_in) |=> mib_addr_out == 11'h601 && mib_rd_out)
    else $error("user op not sent to 3001");

  // program counter moves by the instruction length in bytes
  a_pc_advance: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (exec_in && !pc_load_en_in) |=> pc_out == $past(pc_out) + {13'h0, $past(words_in), 1'b0})
    else $error("pc not advanced");

  // an override wins over the advance
  a_pc_load: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    pc_load_en_in |=> pc_out == $past(pc_load_in))
    else $error("pc override lost");

  // reserved trap pushes two words through the stack pointer
  a_sp_push: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (exec_in && dispatch && !ustore_en_in) |=> sp_out == $past(sp_out) - 16'h0004)
    else $error("stack pointer not pushed");

  // operand mode fields are captured with each instruction
  a_mode_capture: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    exec_in |=> (src_mode_out == $past(opcode_in[11:9])) &&
    (dst_mode_out == $past(opcode_in[5:3])) && (pc_mode_out == ($past(opcode_in[2:0]) == 3'h7)))
    else $error("operand modes not captured");

endmodule

/* core/status_dispatch_map.svh */
// constants for the status byte and opcode dispatch block
`ifndef STATUS_DISPATCH_MAP_SVH
`define STATUS_DISPATCH_MAP_SVH
`define PSB_BIT_PRIO      7
`define PSB_BIT_TRACE     4
`define PSB_BIT_N         3
`define PSB_BIT_Z         2
`define PSB_BIT_V         1
`define PSB_BIT_C         0
`define PSB_PRIO_IDX      7
`define PSB_WORK_MASK     8'h9f
`define PSB_RESET         8'h00
`define UADDR_OP220       11'h600
`define UADDR_OP0766      11'h601
`define UADDR_OP0750      11'h603
`define TRAP_VEC_RESERVED 16'h0008
`define OP_USER_LO        16'h7dc0
`define OP_USER_HI        16'h7dff
`define OP_EXT_LO         16'h7a20
`define OP_EXT_HI         16'h7bff
`define OP_0766_BASE      16'h7c00
`define OP_220_BASE       16'h0090
`define OP_DUMP_BASE      16'h0088
`define MIB_WAIT_CYCLES   2
`endif

/* core/status_dispatch_pkg.sv */
// types shared by the status byte and opcode dispatch block
package status_dispatch_pkg;
  // instruction class seen by the status byte logic
  typedef enum logic [7:0] {
    CLS_DATA     = 8'h01,
    CLS_CONTROL  = 8'h02,
    CLS_TRAP     = 8'h04,
    CLS_CCOP     = 8'h08,
    CLS_FROM_PSB = 8'h10,
    CLS_TO_PSB   = 8'h20,
    CLS_DISPATCH = 8'h40,
    CLS_DUMP     = 8'h80
  } op_class_t;
  // microstore fetch sequencer states
  typedef enum logic [2:0] {
    FS_IDLE = 3'b001,
    FS_WAIT = 3'b010,
    FS_DONE = 3'b100
  } fetch_state_t;
endpackage

/* core/ustore_fetch_port.sv */
// read-only microinstruction bus port with registered read data
`timescale 1ns/1ps
`include "status_dispatch_map.svh"
module ustore_fetch_port
  import status_dispatch_pkg::*;
(
  input  wire logic        mclk_in,       // core clock
  input  wire logic        rstn_in,       // async reset, active low
  input  wire logic        start_in,      // one-cycle fetch request
  input  wire logic [10:0] uaddr_in,      // microaddress to fetch
  input  wire logic [23:0] mib_data_in,   // word returned by the store
  output logic [10:0]      mib_addr_out,  // microaddress driven out
  output logic             mib_rd_out,    // read strobe, never a write
  output logic [23:0]      uword_out,     // registered microinstruction
  output logic             uvalid_out     // one-cycle valid pulse
);
  // ----------------------------------------------------------------
  // fetch sequencer
  // ----------------------------------------------------------------
  fetch_state_t state;                    // current state
  fetch_state_t next_state;               // next state
  logic [1:0]   wait_cnt;                 // cycles waited for data
  wire          wait_over = (wait_cnt == 2'(`MIB_WAIT_CYCLES - 1));

  // next state decode; the port only reads, the store is never written
  always_comb
  begin
    case (state)
      FS_IDLE: next_state = start_in ? FS_WAIT : FS_IDLE;
      FS_WAIT: next_state = wait_over ? FS_DONE : FS_WAIT;
      FS_DONE: next_state = FS_IDLE;
      default: next_state = FS_IDLE;
    endcase
  end

  // address and strobe held for the whole access so the cable settles
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state        <= FS_IDLE;
      wait_cnt     <= 2'h0;
      mib_addr_out <= 11'h000;
      mib_rd_out   <= 1'b0;
      uword_out    <= 24'h00_0000;
      uvalid_out   <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      uvalid_out <= 1'b0;
      if (state == FS_IDLE && start_in)
      begin
        mib_addr_out <= uaddr_in;
        mib_rd_out   <= 1'b1;
        wait_cnt     <= 2'h0;
      end
      else if (state == FS_WAIT)
      begin
        wait_cnt <= wait_cnt + 2'h1;
        if (wait_over)
        begin
          uword_out  <= mib_data_in;
          uvalid_out <= 1'b1;
          mib_rd_out <= 1'b0;
        end
      end
    end
  end

  // a fetch returns data a fixed time after it starts
  a_fetch_latency: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (state == FS_IDLE && start_in) |-> ##3 uvalid_out)
    else $error("fetch did not complete in time");
endmodule

/* verif/microstore_model.sv */
// behavioural preloaded microstore on the read-only microinstruction bus
`timescale 1ns/1ps
module microstore_model
(
  input  wire logic        mclk_in,      // core clock
  input  wire logic [10:0] mib_addr_in,  // microaddress from the core
  input  wire logic        mib_rd_in,    // read strobe from the core
  output logic      [23:0] mib_data_out  // word returned to the core
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [23:0] mem [1024];  // 1024 words of 24 bits
  logic [23:0] last_word;   // last word shown on the bus
  // address-derived fill, so a microaddress wrong in its low ten bits returns a wrong word
  initial
  begin
    for (int i = 0; i < 1024; i++)
      mem[i] = 24'h5a_0000 ^ 24'(i);
    last_word = 24'h00_0000;
  end
  // remember what was driven so an idle bus can show its inverse
  always @(posedge mclk_in)
    last_word <= mib_data_out;
  // read only: no write path; an idle bus toggles so stale data never matches
  assign mib_data_out = mib_rd_in ? mem[mib_addr_in[9:0]] : ~last_word;
endmodule

/* verif/tb_top.sv */
// self-checking bench for the status byte and opcode dispatch block
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("mismatch at %0t got %h expected %h", $time, (got), (exp)); \
    end \
  end
module tb_top;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic        mclk_in       = 1'b0;      // 50 MHz core clock
  logic        rstn_in       = 1'b0;      // reset, active low
  logic        exec_in       = 1'b0;      // execute strobe
  logic [15:0] opcode_in     = 16'h0000;  // instruction word
  logic [1:0]  words_in      = 2'h1;      // instruction length in words
  logic [3:0]  alu_flags_in  = 4'h0;      // alu flags
  logic [7:0]  load_byte_in  = 8'h00;     // byte for status loads
  logic [15:0] pc_load_in    = 16'h0000;  // program counter override
  logic        pc_load_en_in = 1'b0;      // override enable
  logic [15:0] dump_base_in  = 16'h0000;  // dump base register
  logic        ustore_en_in  = 1'b0;      // user microstore fitted
  logic [23:0] mib_data_in;               // from the microstore model
  logic [7:0]  status_out;
  logic [15:0] pc_out, sp_out, from_psb_out, dump_reg_out, trap_vec_out;
  logic [2:0]  src_mode_out, dst_mode_out;
  logic [10:0] mib_addr_out;
  logic [23:0] uword_out;
  logic        trap_out, pc_mode_out, mib_rd_out, uvalid_out;
  int          miscompares  = 0;          // failed comparisons
  int          total_checks = 0;          // comparisons made
  int          cycles       = 0;          // cycles since start
  logic [7:0]  st;                        // expected status byte
  logic [15:0] cc_op [5]    = '{16'h00bf, 16'h00a4, 16'h00b0, 16'h00af, 16'h00b8};
  logic [7:0]  mf_src [3]   = '{8'h00, 8'h81, 8'hfe};
  logic [15:0] dsp_op [6]   = '{16'h0090, 16'h0097, 16'h7a20, 16'h7bff, 16'h7c00, 16'h7dff};
  logic [10:0] dsp_addr [6] = '{11'h600, 11'h600, 11'h603, 11'h603, 11'h601, 11'h601};

  status_dispatch status_dispatch_inst (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .exec_in(exec_in), .opcode_in(opcode_in),
    .words_in(words_in), .alu_flags_in(alu_flags_in), .load_byte_in(load_byte_in),
    .pc_load_in(pc_load_in), .pc_load_en_in(pc_load_en_in), .dump_base_in(dump_base_in),
    .ustore_en_in(ustore_en_in), .mib_data_in(mib_data_in), .status_out(status_out),
    .pc_out(pc_out), .sp_out(sp_out), .from_psb_out(from_psb_out), .dump_reg_out(dump_reg_out),
    .trap_out(trap_out), .trap_vec_out(trap_vec_out), .src_mode_out(src_mode_out),
    .dst_mode_out(dst_mode_out), .pc_mode_out(pc_mode_out), .mib_addr_out(mib_addr_out),
    .mib_rd_out(mib_rd_out), .uword_out(uword_out), .uvalid_out(uvalid_out));
  microstore_model microstore_model_inst (
    .mclk_in(mclk_in), .mib_addr_in(mib_addr_out), .mib_rd_in(mib_rd_out), .mib_data_out(mib_data_in));

  // ------------------------------------------------------------
  // clock, watchdog and shared tasks
  // ------------------------------------------------------------
  initial
  begin
    forever #10 mclk_in = ~mclk_in;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  // one execute strobe, driven on falling edges; returns once results land
  task automatic run_op(input logic [15:0] op, input logic [7:0] lb, input logic [3:0] fl, input logic [1:0] w);
    @(negedge mclk_in);
    opcode_in = op;
    load_byte_in = lb;
    alu_flags_in = fl;
    words_in = w;
    exec_in = 1'b1;
    @(negedge mclk_in);
    exec_in = 1'b0;
  endtask
  task automatic test_end(input string name);
    $display("test %s finished, mismatches so far %0d", name, miscompares);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // word the model holds at a microaddress (only ten address bits decode)
  function automatic logic [23:0] word_at(input logic [10:0] a);
    return 24'h5a_0000 ^ {14'h0000, a[9:0]};
  endfunction

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (12) @(negedge mclk_in);
    rstn_in = 1'b1;
    `CHK(status_out, 8'h00)
    `CHK(sp_out, 16'h0000)
    test_end("reset");
    // trap class loads every working bit; reserved bits stay clear
    run_op(16'h8800, 8'hff, 4'h0, 2'h1);
    `CHK(status_out, 8'h9f)
    `CHK(sp_out, 16'hfffc)
    // move-to clears trace but can never set it
    run_op(16'h8d00, 8'h00, 4'h0, 2'h1);
    `CHK(status_out, 8'h00)
    run_op(16'h8d00, 8'hff, 4'h0, 2'h1);
    `CHK(status_out, 8'h8f)
    run_op(16'h8800, 8'hff, 4'h0, 2'h1);
    run_op(16'h8d00, 8'h10, 4'h0, 2'h1);
    `CHK(status_out, 8'h10)
    test_end("status loads");
    // data op takes alu flags, keeps bits 7 and 4, ignores the load byte
    run_op(16'h14e5, 8'hff, 4'h5, 2'h1);
    `CHK(status_out, 8'h15)
    `CHK(src_mode_out, 3'h2)
    `CHK(dst_mode_out, 3'h4)
    `CHK(pc_mode_out, 1'b0)
    run_op(16'h0100, 8'hff, 4'ha, 2'h1);
    `CHK(status_out, 8'h15)
    run_op(16'h0005, 8'hff, 4'ha, 2'h1);
    `CHK(status_out, 8'h15)
    test_end("data and control");
    // condition-code operators, including the no-operation form
    st = 8'h15;
    foreach (cc_op[i])
    begin
      run_op(cc_op[i], 8'hff, 4'hf, 2'h1);
      st = cc_op[i][4] ? (st | {4'h0, cc_op[i][3:0]}) : (st & ~{4'h0, cc_op[i][3:0]});
      `CHK(status_out, st)
    end
    // move-from: sign fill, then N from bit 7, Z on all zero, V clear, C kept
    foreach (mf_src[i])
    begin
      run_op(16'h8800, mf_src[i], 4'h0, 2'h1);
      st = mf_src[i] & 8'h9f;
      run_op(16'h8dc0, 8'h00, 4'hf, 2'h1);
      `CHK(from_psb_out, {{8{st[7]}}, st})
      st = {st[7:4], st[7], st == 8'h00, 1'b0, st[0]};
      `CHK(status_out, st)
    end
    test_end("status operators");
    // program counter override, then advance by instruction length
    @(negedge mclk_in);
    pc_load_in = 16'h1000;
    pc_load_en_in = 1'b1;
    @(negedge mclk_in);
    pc_load_en_in = 1'b0;
    `CHK(pc_out, 16'h1000)
    run_op(16'h14e5, 8'h00, 4'h0, 2'h3);
    `CHK(pc_out, 16'h1006)
    run_op(16'h00b0, 8'h00, 4'h0, 2'h1);
    `CHK(pc_out, 16'h1008)
    dump_base_in = 16'h2000;
    run_op(16'h0088, 8'h00, 4'h0, 2'h1);
    `CHK(dump_reg_out, 16'h200a)
    test_end("pc and dump");
    // dispatch with the store fitted, then reserved trap without it
    run_op(16'h8800, 8'h81, 4'h0, 2'h1);
    st = 8'h81;
    for (int e = 1; e >= 0; e--)
    begin
      ustore_en_in = (e == 1);
      foreach (dsp_op[i])
      begin
        if (e == 0 && dsp_op[i][15:8] == 8'h7c)
          continue;
        run_op(dsp_op[i], 8'h00, 4'hf, 2'h1);
        `CHK(trap_out, e == 0)
        `CHK(status_out, st)
        if (e == 1)
        begin
          `CHK(mib_addr_out, dsp_addr[i])
          `CHK(mib_rd_out, 1'b1)
          for (int k = 0; k < 4 && uvalid_out !== 1'b1; k++)
            @(negedge mclk_in);
          `CHK(uvalid_out, 1'b1)
          `CHK(uword_out, word_at(dsp_addr[i]))
        end
        else
          `CHK(trap_vec_out, 16'h0008)
        repeat (3) @(negedge mclk_in);
      end
    end
    test_end("dispatch");
    tally_and_finish();
  end
endmodule
